// *** src/flow_seq_pkg.sv ***
// package for the program-flow sequencer: address map, opcode layout, reset values
// assumes a 13-bit program address and 16-bit one-word instructions
package flow_seq_pkg;

  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned ROM_WORDS   = 7932;
  localparam logic [12:0] ADDR_FIRST  = 13'h0000;
  localparam logic [12:0] ADDR_LAST   = 13'h1efb;
  localparam logic [12:0] PAGE1_BASE  = 13'h0800;
  localparam logic [12:0] PAGE2_BASE  = 13'h1000;
  localparam logic [12:0] PAGE3_BASE  = 13'h1800;

  // instruction word layout
  localparam int unsigned OP_MSB      = 15;
  localparam int unsigned OP_LSB      = 11;
  localparam int unsigned OPND_MSB    = 10;
  localparam int unsigned SUB_MSB     = 2;

  // opcodes (5 bits)
  localparam logic [4:0]  OP_JUMP_P0  = 5'h0c;
  localparam logic [4:0]  OP_JUMP_P1  = 5'h0d;
  localparam logic [4:0]  OP_JUMP_P2  = 5'h0e;
  localparam logic [4:0]  OP_JUMP_P3  = 5'h0f;
  localparam logic [4:0]  OP_CALL_DIR = 5'h1c;
  localparam logic [4:0]  OP_FLOW_IND = 5'h1f;

  // sub-codes in the low operand bits of OP_FLOW_IND
  localparam logic [2:0]  SUB_JUMP_IND = 3'h1;
  localparam logic [2:0]  SUB_CALL_IND = 3'h2;
  localparam logic [2:0]  SUB_EXIT     = 3'h3;
  localparam logic [2:0]  SUB_EXIT_SKP = 3'h4;
  localparam logic [2:0]  SUB_TABLE    = 3'h5;

  // reset values
  localparam logic [12:0] FP_RESET    = 13'h0000;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam int unsigned STACK_DEPTH_DEF = 8;

  typedef enum logic [0:0] {ST_EXEC, ST_TABLE} seq_state_t;

endpackage

// *** src/program_flow_sequencer.sv ***
// program-flow sequencer: fetch pointer, jumps, calls, exits, table fetch, interrupt vectoring
// assumes the core supplies the indirect pointer and interrupt requests on mclk
`timescale 1ns/10ps
module program_flow_sequencer
  import flow_seq_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = STACK_DEPTH_DEF,
  parameter int unsigned SI_W        = $clog2(STACK_DEPTH)
)
(
  input  wire logic            mclk,                 // instruction clock
  input  wire logic            rst,                  // synchronous reset, active high
  input  wire logic [12:0]     indirect_pointer_reg, // indirect target from the core
  input  wire logic            irq_req,              // interrupt pending, level
  input  wire logic [12:0]     irq_vector,           // vector of the pending interrupt
  output      logic            irq_ack,              // interrupt accepted this cycle
  output      logic [12:0]     fetch_pointer,        // address being fetched
  output      logic            exec_valid,           // instruction issued to the core
  output      logic [15:0]     exec_word,            // issued instruction word
  output      logic [12:0]     exec_addr,            // address of issued word
  output      logic            exec_nop,             // issued word is to be a no-op
  output      logic [15:0]     table_read_buffer,    // constant word from table fetch
  output      logic            table_load,           // buffer loaded this cycle
  output      logic [SI_W-1:0] stack_index           // return stack fill level
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  seq_state_t      state_reg;
  seq_state_t      state_next;
  logic [12:0]     fp_reg;
  logic [12:0]     fp_next;
  logic            skip_reg;
  logic            skip_next;
  logic [SI_W-1:0] si_reg;
  logic [12:0]     return_stack [STACK_DEPTH];
  logic [15:0]     exec_word_reg;
  logic [12:0]     exec_addr_reg;
  logic            exec_valid_reg;
  logic            exec_nop_reg;
  logic [15:0]     buf_reg;
  logic            table_load_reg;

  ////////////////////////////////////////////////////////////////////////////
  // program store read, one word per fetch
  logic [15:0] rom_word;

  program_store #(
    .WORDS   (ROM_WORDS)
  ) u_store (
    .rd_addr (fp_reg),
    .rd_data (rom_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [4:0]  op_field   = rom_word[OP_MSB:OP_LSB];
  wire [10:0] opnd_field = rom_word[OPND_MSB:0];
  wire [2:0]  sub_field  = rom_word[SUB_MSB:0];
  wire        in_exec    = (state_reg == ST_EXEC);

  // interrupts wait while a no-op is owed, so the skip never lands on the vector;
  // the owed slot issues even with a request pending, keeping the step count
  wire take_irq  = in_exec && irq_req && !skip_reg;
  wire decode_ok = in_exec && !irq_req && !skip_reg;
  wire decode_nop_slot = in_exec && skip_reg;

  wire is_jump_dir = decode_ok && (op_field[4:2] == OP_JUMP_P0[4:2]);
  wire is_call_dir = decode_ok && (op_field == OP_CALL_DIR);
  wire is_ind      = decode_ok && (op_field == OP_FLOW_IND);
  wire is_jump_ind = is_ind && (sub_field == SUB_JUMP_IND);
  wire is_call_ind = is_ind && (sub_field == SUB_CALL_IND);
  wire is_exit     = is_ind && (sub_field == SUB_EXIT);
  wire is_exit_skp = is_ind && (sub_field == SUB_EXIT_SKP);
  wire is_table    = is_ind && (sub_field == SUB_TABLE);
  wire table_done  = (state_reg == ST_TABLE);

  // page comes from the low opcode bits; direct calls are held to page 0
  wire [12:0] jump_dir_target = {op_field[1:0], opnd_field};
  wire [12:0] call_dir_target = {2'b00, opnd_field};
  wire [12:0] fp_inc          = fp_reg + 13'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // return stack control
  // interrupt returns to the instruction it pre-empted, which was not issued
  wire        push_en   = take_irq || is_call_dir || is_call_ind || is_table;
  wire        pop_en    = is_exit || is_exit_skp || table_done;
  wire [12:0] push_data = take_irq ? fp_reg : fp_inc;
  wire [SI_W-1:0] si_top = si_reg - SI_W'(1);
  wire [12:0] pop_data  = return_stack[si_top];

  // stack wraps on overflow or underflow; depth limits are software's concern
  wire [STACK_DEPTH-1:0] entry_we;

  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++)
    begin : g_stack
      // only the slot at the fill level takes the pushed address
      assign entry_we[gi] = push_en && (si_reg == SI_W'(gi));

      always_ff @(posedge mclk)
      begin
        if (rst)
          return_stack[gi] <= FP_RESET;
        else if (entry_we[gi])
          return_stack[gi] <= push_data;
      end
    end
  endgenerate

  // push and pop never share a cycle: exits are not decoded while an interrupt is taken
  wire [SI_W-1:0] si_next = push_en ? si_reg + SI_W'(1) :
                            pop_en  ? si_top :
                            si_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
      si_reg <= '0;
    else
      si_reg <= si_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next fetch pointer and sequencing
  always_comb
  begin
    state_next = state_reg;
    fp_next    = fp_inc;
    skip_next  = skip_reg;
    case (state_reg)
      ST_EXEC:
      begin
        if (take_irq)
          fp_next = irq_vector;
        else if (skip_reg)
          skip_next = 1'b0;
        else if (is_jump_dir)
          fp_next = jump_dir_target;
        else if (is_call_dir)
          fp_next = call_dir_target;
        else if (is_jump_ind || is_call_ind)
          fp_next = indirect_pointer_reg;
        else if (is_exit)
          fp_next = pop_data;
        else if (is_exit_skp)
        begin
          fp_next   = pop_data;
          skip_next = 1'b1;
        end
        else if (is_table)
        begin
          fp_next    = indirect_pointer_reg;
          state_next = ST_TABLE;
        end
      end
      ST_TABLE:
      begin
        // second cycle: pointer is on the table word, then go back
        fp_next    = pop_data;
        state_next = ST_EXEC;
      end
      default:
      begin
        state_next = ST_EXEC;
        fp_next    = FP_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= ST_EXEC;
      fp_reg    <= FP_RESET;
      skip_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      fp_reg    <= fp_next;
      skip_reg  <= skip_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue to the core and table buffer
  // a no-op slot still issues, so the core sees the same number of steps
  wire        issue_en       = decode_ok || decode_nop_slot;
  wire [15:0] exec_word_next = issue_en ? rom_word : exec_word_reg;
  wire [12:0] exec_addr_next = issue_en ? fp_reg : exec_addr_reg;
  wire [15:0] buf_next       = table_done ? rom_word : buf_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      exec_valid_reg <= 1'b0;
      exec_nop_reg   <= 1'b0;
    end
    else
    begin
      exec_valid_reg <= issue_en;
      exec_nop_reg   <= decode_nop_slot;
    end
  end

  // word and address hold between issues so the core may read them late
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      exec_word_reg <= WORD_RESET;
      exec_addr_reg <= FP_RESET;
    end
    else
    begin
      exec_word_reg <= exec_word_next;
      exec_addr_reg <= exec_addr_next;
    end
  end

  // the buffer keeps the last table word until the next table fetch
  always_ff @(posedge mclk)
  begin
    if (rst)
      table_load_reg <= 1'b0;
    else
      table_load_reg <= table_done;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      buf_reg <= WORD_RESET;
    else
      buf_reg <= buf_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_ack           = take_irq;
  assign fetch_pointer     = fp_reg;
  assign exec_valid        = exec_valid_reg;
  assign exec_word         = exec_word_reg;
  assign exec_addr         = exec_addr_reg;
  assign exec_nop          = exec_nop_reg;
  assign table_read_buffer = buf_reg;
  assign table_load        = table_load_reg;
  assign stack_index       = si_reg;

endmodule

// *** src/program_store.sv ***
// read-only program store, 16-bit word per address, combinational read
// assumes the reader registers what it needs; contents are fixed at build time
`timescale 1ns/10ps
module program_store
  import flow_seq_pkg::*;
#(
  parameter int unsigned WORDS = ROM_WORDS
)
(
  input  wire logic [12:0] rd_addr, // word address
  output      logic [15:0] rd_data  // word at rd_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // no write port exists: contents cannot change at run time
  function automatic logic [15:0] image_word(input logic [12:0] a);
    logic [15:0] w;
    w = WORD_RESET;
    case (a)
      13'h0001: w = {OP_CALL_DIR, 11'h010};
      13'h0002: w = {OP_FLOW_IND, 8'h00, SUB_JUMP_IND};
      13'h0003: w = {OP_JUMP_P1, 11'h100};
      13'h0010: w = {OP_FLOW_IND, 8'h00, SUB_TABLE};
      13'h0011: w = {OP_FLOW_IND, 8'h00, SUB_EXIT_SKP};
      13'h0900: w = {OP_FLOW_IND, 8'h00, SUB_CALL_IND};
      13'h0901: w = {OP_JUMP_P0, 11'h000};
      13'h0a00: w = {OP_FLOW_IND, 8'h00, SUB_EXIT};
      13'h0a01: w = 16'h1234;
      default:  w = WORD_RESET;
    endcase
    return w;
  endfunction

  // beyond the last word the store answers zero
  wire         in_range = (32'(rd_addr) < WORDS);
  assign rd_data = in_range ? image_word(rd_addr) : WORD_RESET;

endmodule

// *** verification/core_side_model.sv ***
// core stand-in: pointer register and interrupt requester
// assumes the bench pulses fire for one cycle to raise a request
`timescale 1ns/10ps
module core_side_model
(
  input  wire logic        mclk,                 // clock
  input  wire logic        fire,                 // raise a request
  input  wire logic [12:0] vec,                  // vector to present
  input  wire logic [12:0] ptr,                  // pointer from the bench
  input  wire logic        irq_ack,              // request taken
  output      logic        irq_req = 1'b0,       // level request
  output      logic [12:0] irq_vector = 13'h0,   // valid with request only
  output      logic [12:0] indirect_pointer_reg  // indirect target
);
  assign indirect_pointer_reg = ptr;
  // request held until taken; vector scrambled when idle so no stale value helps
  always @(posedge mclk)
  begin
    irq_req <= #1 irq_req ? !irq_ack : fire;
    irq_vector <= #1 (fire || (irq_req && !irq_ack)) ? vec : ~irq_vector;
  end
endmodule

// *** verification/flow_seq_sva.sv ***
// port checker for the program-flow sequencer
// assumes mclk only and synchronous active-high rst
`timescale 1ns/10ps
module flow_seq_sva
  import flow_seq_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = STACK_DEPTH_DEF,
  parameter int unsigned SI_W        = $clog2(STACK_DEPTH)
)
(
  input wire logic            mclk,                 // clock
  input wire logic            rst,                  // reset
  input wire logic [12:0]     indirect_pointer_reg, // pointer
  input wire logic            irq_req,              // request
  input wire logic [12:0]     irq_vector,           // vector
  input wire logic            irq_ack,              // taken
  input wire logic [12:0]     fetch_pointer,        // fetch address
  input wire logic            exec_valid,           // issue
  input wire logic [15:0]     exec_word,            // word
  input wire logic [12:0]     exec_addr,            // address
  input wire logic            exec_nop,             // no-op
  input wire logic [15:0]     table_read_buffer,    // buffer
  input wire logic            table_load,           // load
  input wire logic [SI_W-1:0] stack_index           // fill level
);
  wire [4:0] op    = exec_word[15:11];
  wire [2:0] sub   = exec_word[2:0];
  wire       live  = exec_valid && !exec_nop;
  wire       ind   = live && op == OP_FLOW_IND;
  wire       plain = op[4:2] != 3'b011 && op != OP_CALL_DIR && op != OP_FLOW_IND;
  ////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_tab_issue;
    ind && sub == SUB_TABLE;
  endsequence
  sequence s_tab_done;
    table_load && !exec_valid && fetch_pointer == $past(exec_addr) + 13'h1;
  endsequence
  a_reset_start: assert property (
    $fell(rst) |-> fetch_pointer == FP_RESET && stack_index == '0) else $error("bad start");
  a_jump_direct: assert property (
    live && op[4:2] == 3'b011 |-> fetch_pointer == exec_word[12:0]) else $error("bad jump");
  a_jump_indirect: assert property (
    ind && sub == SUB_JUMP_IND |-> fetch_pointer == $past(indirect_pointer_reg))
    else $error("bad indirect jump");
  a_call_page0: assert property (live && op == OP_CALL_DIR |->
    fetch_pointer == {2'b00, exec_word[10:0]} && stack_index == SI_W'($past(stack_index) + 1))
    else $error("bad call");
  a_exit_pop: assert property (ind && (sub == SUB_EXIT || sub == SUB_EXIT_SKP) |->
    stack_index == SI_W'($past(stack_index) - 1)) else $error("bad exit");
  a_skip_nop: assert property (ind && sub == SUB_EXIT_SKP |=>
    exec_valid && exec_nop && exec_addr == $past(fetch_pointer)) else $error("no skip");
  a_count_up: assert property (
    exec_valid && (exec_nop || plain) |-> fetch_pointer == exec_addr + 13'h1)
    else $error("no count");
  a_table_steps: assert property (s_tab_issue |=> s_tab_done)
    else $error("bad table fetch");
  a_irq_vector: assert property (
    irq_ack |=> fetch_pointer == $past(irq_vector) && !exec_valid) else $error("bad vector");
  a_irq_push: assert property (irq_ack |=> stack_index == SI_W'($past(stack_index) + 1))
    else $error("interrupt did not push");
endmodule
bind program_flow_sequencer flow_seq_sva #(.STACK_DEPTH(STACK_DEPTH), .SI_W(SI_W)) chk_u (
  .mclk(mclk), .rst(rst), .indirect_pointer_reg(indirect_pointer_reg), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_ack(irq_ack), .fetch_pointer(fetch_pointer),
  .exec_valid(exec_valid), .exec_word(exec_word), .exec_addr(exec_addr), .exec_nop(exec_nop),
  .table_read_buffer(table_read_buffer), .table_load(table_load), .stack_index(stack_index));

// *** verification/program_flow_sequencer_tb.sv ***
// self-checking bench: reference model of fetch, stack, table and interrupt flow
// assumes the fixed store image of the sequencer and an 8-deep wrapping stack
`timescale 1ns/10ps
module program_flow_sequencer_tb;
  import flow_seq_pkg::*;
  logic        mclk, irq_req, irq_ack, exec_valid, exec_nop, table_load;
  logic        rst = 1'b1, fire = 1'b0, ev, en, tl, mskip, mtab;
  logic [12:0] ptr = 13'h0, vec = 13'h0, irq_vector, indirect_pointer_reg;
  logic [12:0] fetch_pointer, exec_addr, mfp, ea, stk [8];
  logic [15:0] exec_word, table_read_buffer, ew, mb, w;
  logic [2:0]  stack_index, si;
  int          failures = 0, n_checks = 0, cyc = 0;
  ////////////////////////////////////////////////
  function automatic logic [15:0] rom(logic [12:0] a);
    case (a)
      13'h0001: rom = {OP_CALL_DIR, 11'h010};
      13'h0002: rom = {OP_FLOW_IND, 8'h00, SUB_JUMP_IND};
      13'h0003: rom = {OP_JUMP_P1, 11'h100};
      13'h0010: rom = {OP_FLOW_IND, 8'h00, SUB_TABLE};
      13'h0011: rom = {OP_FLOW_IND, 8'h00, SUB_EXIT_SKP};
      13'h0900: rom = {OP_FLOW_IND, 8'h00, SUB_CALL_IND};
      13'h0901: rom = {OP_JUMP_P0, 11'h000};
      13'h0a00: rom = {OP_FLOW_IND, 8'h00, SUB_EXIT};
      13'h0a01: rom = 16'h1234;
      default: rom = 16'h0000;
    endcase
  endfunction
  task automatic call(logic [12:0] t, logic tab);
    stk[si] = mfp;
    si = si + 3'h1;
    mfp = t;
    mtab = tab;
  endtask
  task automatic pop(logic s);
    si = si - 3'h1;
    mfp = stk[si];
    mskip = s;
  endtask
  task automatic step();
    {ev, tl, en} = 3'b000;
    if (rst)
    begin
      {mfp, si, mskip, mtab, en, ew, ea, mb} = '0;
      foreach (stk[i])
        stk[i] = 13'h0;
    end
    else if (mtab)
    begin
      mb = rom(mfp);
      pop(1'b0);
      {tl, mtab} = 2'b10;
    end
    else if (irq_req && !mskip)
      call(irq_vector, 1'b0);
    else
    begin
      w = rom(mfp);
      {ev, ew, ea, en, mskip} = {1'b1, w, mfp, mskip, 1'b0};
      mfp = mfp + 13'h1;
      if (!en)
        case (w[15:11])
          OP_JUMP_P0, OP_JUMP_P1, OP_JUMP_P2, OP_JUMP_P3: mfp = w[12:0];
          OP_CALL_DIR: call({2'b00, w[10:0]}, 1'b0);
          OP_FLOW_IND:
            case (w[2:0])
              SUB_JUMP_IND: mfp = indirect_pointer_reg;
              SUB_CALL_IND: call(indirect_pointer_reg, 1'b0);
              SUB_EXIT: pop(1'b0);
              SUB_EXIT_SKP: pop(1'b1);
              SUB_TABLE: call(indirect_pointer_reg, 1'b1);
              default: ;
            endcase
          default: ;
        endcase
    end
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one clock: model follows the edge, inputs move 1 ns later, outputs read at 2 ns
  task automatic cycle(logic r, logic f);
    @(posedge mclk);
    step();
    #1;
    {rst, fire} = {r, f};
    ptr = mfp == 13'h0010 ? 13'h0a01 : mfp == 13'h0900 ? 13'h0a00 : 13'($urandom);
    #1;
    if (!rst)
    begin
      check(fetch_pointer, mfp);
      check(stack_index, si);
      check(exec_valid, ev);
      check(exec_word, ew);
      check(exec_addr, ea);
      check(exec_nop, en);
      check(table_load, tl);
      check(table_read_buffer, mb);
      check(irq_ack, irq_req && !mtab && !mskip);
    end
  endtask
  ////////////////////////////////////////////////
  program_flow_sequencer dut_u (.mclk(mclk), .rst(rst), .indirect_pointer_reg(indirect_pointer_reg),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .fetch_pointer(fetch_pointer),
    .exec_valid(exec_valid), .exec_word(exec_word), .exec_addr(exec_addr), .exec_nop(exec_nop),
    .table_read_buffer(table_read_buffer), .table_load(table_load), .stack_index(stack_index));
  core_side_model core_u (.mclk(mclk), .fire(fire), .vec(vec), .ptr(ptr), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .indirect_pointer_reg(indirect_pointer_reg));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // bursts of 12 x 45 to 73 cycles; the ceiling leaves ample margin
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    void'($urandom(32'he29d));
    repeat (2) cycle(1'b1, 1'b0);
    for (int b = 0; b < 12; b++)
    begin
      vec = b % 4 == 0 ? 13'h0002 : b % 4 == 1 ? 13'h0900 : b % 4 == 2 ? 13'h0010 : 13'($urandom);
      repeat ($urandom_range(30, 2)) cycle(1'b0, 1'b0);
      cycle(1'b0, 1'b1);
      repeat (40) cycle(1'b0, 1'b0);
      repeat (2) cycle(1'b1, 1'b0);
    end
    close_out();
  end
endmodule
